/* File: src/fsp_defines.svh */
// Constants of the flash status word and protection logic.
// Assumes inclusion by bare name from the design files.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
`define FSP_BIT_BUSY 0
`define FSP_BIT_WLATCH 1
`define FSP_BIT_SEL_LO 2
`define FSP_BIT_SEL_HI 6
`define FSP_BIT_LOCK_LO 7
`define FSP_BIT_LOCK_HI 8
`define FSP_BIT_FOUR_LANE 9
`define FSP_BIT_SEC_LOCK 10
`define FSP_BIT_FAST 13
`define FSP_BIT_INVERT 14
`define FSP_BIT_SUSP 15
`define FSP_STATUS_RESET 16'h0000
`define FSP_WRITABLE_MASK 16'h47FC
`define FSP_ADDR_TOP 20'hFFFFF
`define FSP_OP_CYCLES 16'h0010
`endif

/* File: src/fsp_pkg.sv */
// Types shared by the flash status and protection design.
// Assumes the defines header is on the include path.
package fsp_pkg;
   typedef enum logic [3:0] {
      FSP_CMD_NONE,
      FSP_CMD_WRITE_ENABLE_CMD,
      FSP_CMD_WRDI,
      FSP_CMD_STATUS_WRITE_CMD,
      FSP_CMD_PROG,
      FSP_CMD_SERASE,
      FSP_CMD_BERASE,
      FSP_CMD_CERASE,
      FSP_CMD_SUSPEND,
      FSP_CMD_RESUME,
      FSP_CMD_FAST_ON,
      FSP_CMD_FAST_OFF
   } fsp_cmd_type;
   typedef struct packed {
      fsp_cmd_type op;
      logic [19:0] addr;
      logic [15:0] data;
   } fsp_req_type;
   typedef struct packed {
      logic accepted;
      logic rejected;
   } fsp_ans_type;
   typedef struct packed {
      logic [19:0] lo;
      logic [19:0] hi;
      logic any;
   } fsp_range_type;
endpackage

/* File: src/fsp_range_decode.sv */
// Decodes protect selection and invert bit into a protected address range.
// Combinational leaf used by the status word block.
`timescale 1ns/100ps
module fsp_range_decode
   import fsp_pkg::*;
(
   // Status fields
   input wire logic [4:0] protSel,
   input wire logic rangeInvert,
   // Decoded range
   output fsp_pkg::fsp_range_type range
);
   `include "fsp_defines.svh"

   function automatic fsp_range_type mk(input logic [19:0] lo, input logic [19:0] hi,
      input logic any);
      fsp_range_type r;
      r.lo = lo;
      r.hi = hi;
      r.any = any;
      return r;
   endfunction

   always_comb
   begin
      range = mk(20'h00000, 20'h00000, 1'b0);
      if (protSel[2:0] == 3'h0)
         range = mk(20'h00000, `FSP_ADDR_TOP, rangeInvert);
      else if (protSel[2:1] == 2'h3 || (protSel[2:0] == 3'h5 && !protSel[4]))
         range = mk(20'h00000, `FSP_ADDR_TOP, !rangeInvert);
      else if (!protSel[4])
      begin
         // Block granular: upper (sel3=0) or lower portion
         unique case ({protSel[3], protSel[2:0]})
            4'h1: range = rangeInvert ? mk(20'h00000, 20'hEFFFF, 1'b1)
                                      : mk(20'hF0000, `FSP_ADDR_TOP, 1'b1);
            4'h2: range = rangeInvert ? mk(20'h00000, 20'hDFFFF, 1'b1)
                                      : mk(20'hE0000, `FSP_ADDR_TOP, 1'b1);
            4'h3: range = rangeInvert ? mk(20'h00000, 20'hBFFFF, 1'b1)
                                      : mk(20'hC0000, `FSP_ADDR_TOP, 1'b1);
            4'h4: range = rangeInvert ? mk(20'h00000, 20'h7FFFF, 1'b1)
                                      : mk(20'h80000, `FSP_ADDR_TOP, 1'b1);
            4'h9: range = rangeInvert ? mk(20'h10000, `FSP_ADDR_TOP, 1'b1)
                                      : mk(20'h00000, 20'h0FFFF, 1'b1);
            4'hA: range = rangeInvert ? mk(20'h20000, `FSP_ADDR_TOP, 1'b1)
                                      : mk(20'h00000, 20'h1FFFF, 1'b1);
            4'hB: range = rangeInvert ? mk(20'h40000, `FSP_ADDR_TOP, 1'b1)
                                      : mk(20'h00000, 20'h3FFFF, 1'b1);
            4'hC: range = rangeInvert ? mk(20'h80000, `FSP_ADDR_TOP, 1'b1)
                                      : mk(20'h00000, 20'h7FFFF, 1'b1);
            default: range = mk(20'h00000, 20'h00000, 1'b0);
         endcase
      end
      else
      begin
         // Sector granular: top (sel3=0) or bottom 4KB to 32KB
         unique case ({protSel[3], protSel[2:0]})
            4'h1: range = rangeInvert ? mk(20'h00000, 20'hFEFFF, 1'b1)
                                      : mk(20'hFF000, `FSP_ADDR_TOP, 1'b1);
            4'h2: range = rangeInvert ? mk(20'h00000, 20'hFDFFF, 1'b1)
                                      : mk(20'hFE000, `FSP_ADDR_TOP, 1'b1);
            4'h3: range = rangeInvert ? mk(20'h00000, 20'hFBFFF, 1'b1)
                                      : mk(20'hFC000, `FSP_ADDR_TOP, 1'b1);
            4'h4, 4'h5: range = rangeInvert ? mk(20'h00000, 20'hF7FFF, 1'b1)
                                            : mk(20'hF8000, `FSP_ADDR_TOP, 1'b1);
            4'h9: range = rangeInvert ? mk(20'h01000, `FSP_ADDR_TOP, 1'b1)
                                      : mk(20'h00000, 20'h00FFF, 1'b1);
            4'hA: range = rangeInvert ? mk(20'h02000, `FSP_ADDR_TOP, 1'b1)
                                      : mk(20'h00000, 20'h01FFF, 1'b1);
            4'hB: range = rangeInvert ? mk(20'h04000, `FSP_ADDR_TOP, 1'b1)
                                      : mk(20'h00000, 20'h03FFF, 1'b1);
            4'hC, 4'hD: range = rangeInvert ? mk(20'h08000, `FSP_ADDR_TOP, 1'b1)
                                            : mk(20'h00000, 20'h07FFF, 1'b1);
            default: range = mk(20'h00000, 20'h00000, 1'b0);
         endcase
      end
   end
endmodule

/* File: src/fsp_status_word.sv */
// Status word, write latch and write protection of a serial flash.
// Assumes decoded, byte-aligned commands arrive as one-cycle pulses.
`timescale 1ns/100ps
module fsp_status_word
   import fsp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clkEn,
   // Command side
   input wire logic reqValid,
   input fsp_pkg::fsp_req_type req,
   input wire logic protectPinN,
   // Status outputs
   output logic [15:0] statusWord,
   output fsp_pkg::fsp_ans_type answer,
   output logic fourLanePins,
   output logic securityReadOnly,
   output logic arrayOpStart
);
   import fsp_pkg::*;
   `include "fsp_defines.svh"

   typedef enum logic [1:0] {
      FSP_IDLE,
      FSP_BUSY
   } fsp_state_type;

   ////////////////////////////////////////////////////////////////////////////
   // Protection decode

   logic [15:0] statusWord_r;
   logic [15:0] statusWord_nxt;
   fsp_range_type range;

   fsp_range_decode uDecode (
      .protSel(statusWord_r[`FSP_BIT_SEL_HI:`FSP_BIT_SEL_LO]),
      .rangeInvert(statusWord_r[`FSP_BIT_INVERT]),
      .range(range)
   );

   function automatic logic in_range(input fsp_range_type r, input logic [19:0] a);
      return r.any && a >= r.lo && a <= r.hi;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   fsp_state_type state_r;
   fsp_state_type state_nxt;
   logic [15:0] opCount_r;
   logic [15:0] opCount_nxt;
   fsp_ans_type answer_r;
   fsp_ans_type answer_nxt;
   logic arrayOpStart_r;
   logic arrayOpStart_nxt;

   logic latchSet;
   logic lockModeHi;
   logic lockModeLo;
   logic statusWriteOk;
   logic pinHigh;
   logic chipEraseOk;
   logic [15:0] wrMask;
   logic [15:0] wrData;

   always_comb
   begin
      latchSet = statusWord_r[`FSP_BIT_WLATCH];
      lockModeHi = statusWord_r[`FSP_BIT_LOCK_HI];
      lockModeLo = statusWord_r[`FSP_BIT_LOCK_LO];
      // Pin carries data once four lanes are on, so it cannot lock then
      pinHigh = protectPinN || fourLanePins;
      // Status write permission by lock mode and protect pin
      unique case ({lockModeHi, lockModeLo})
         2'b00: statusWriteOk = latchSet;
         2'b01: statusWriteOk = latchSet && pinHigh;
         2'b10: statusWriteOk = 1'b0;
         2'b11: statusWriteOk = 1'b0;
      endcase
      chipEraseOk = latchSet &&
         ((statusWord_r[4:2] == 3'h0 && !statusWord_r[`FSP_BIT_INVERT]) ||
          (statusWord_r[4:2] == 3'h7 && statusWord_r[`FSP_BIT_INVERT]));
      wrMask = `FSP_WRITABLE_MASK;
      wrData = (statusWord_r & ~wrMask) | (req.data & wrMask);
      // Security lock is sticky once set
      wrData[`FSP_BIT_SEC_LOCK] = statusWord_r[`FSP_BIT_SEC_LOCK] |
         req.data[`FSP_BIT_SEC_LOCK];
   end

   always_comb
   begin
      statusWord_nxt = statusWord_r;
      state_nxt = state_r;
      opCount_nxt = opCount_r;
      answer_nxt = '0;
      arrayOpStart_nxt = 1'b0;
      unique case (state_r)
         FSP_IDLE:
         begin
            if (reqValid)
            begin
               unique case (req.op)
                  FSP_CMD_WRITE_ENABLE_CMD: statusWord_nxt[`FSP_BIT_WLATCH] = 1'b1;
                  FSP_CMD_WRDI: statusWord_nxt[`FSP_BIT_WLATCH] = 1'b0;
                  FSP_CMD_STATUS_WRITE_CMD:
                  begin
                     if (statusWriteOk)
                     begin
                        statusWord_nxt = wrData;
                        statusWord_nxt[`FSP_BIT_WLATCH] = 1'b0;
                        statusWord_nxt[`FSP_BIT_BUSY] = 1'b1;
                        state_nxt = FSP_BUSY;
                        opCount_nxt = `FSP_OP_CYCLES;
                     end
                     answer_nxt.accepted = statusWriteOk;
                     answer_nxt.rejected = !statusWriteOk;
                  end
                  FSP_CMD_PROG, FSP_CMD_SERASE, FSP_CMD_BERASE, FSP_CMD_CERASE:
                  begin
                     if ((req.op == FSP_CMD_CERASE) ? chipEraseOk
                         : (latchSet && !in_range(range, req.addr)))
                     begin
                        statusWord_nxt[`FSP_BIT_WLATCH] = 1'b0;
                        statusWord_nxt[`FSP_BIT_BUSY] = 1'b1;
                        state_nxt = FSP_BUSY;
                        opCount_nxt = `FSP_OP_CYCLES;
                        arrayOpStart_nxt = 1'b1;
                        answer_nxt.accepted = 1'b1;
                     end
                     else
                        answer_nxt.rejected = 1'b1;
                  end
                  FSP_CMD_RESUME: statusWord_nxt[`FSP_BIT_SUSP] = 1'b0;
                  FSP_CMD_FAST_ON: statusWord_nxt[`FSP_BIT_FAST] = 1'b1;
                  FSP_CMD_FAST_OFF: statusWord_nxt[`FSP_BIT_FAST] = 1'b0;
                  default: ;
               endcase
            end
         end
         FSP_BUSY:
         begin
            if (reqValid && req.op == FSP_CMD_SUSPEND)
            begin
               statusWord_nxt[`FSP_BIT_SUSP] = 1'b1;
               statusWord_nxt[`FSP_BIT_BUSY] = 1'b0;
               state_nxt = FSP_IDLE;
            end
            else if (opCount_r == 16'h0001)
            begin
               statusWord_nxt[`FSP_BIT_BUSY] = 1'b0;
               state_nxt = FSP_IDLE;
               opCount_nxt = 16'h0000;
            end
            else
               opCount_nxt = opCount_r - 16'h0001;
            if (reqValid && req.op != FSP_CMD_SUSPEND)
               answer_nxt.rejected = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         statusWord_r <= `FSP_STATUS_RESET;
         state_r <= FSP_IDLE;
         opCount_r <= 16'h0000;
         answer_r <= '0;
         arrayOpStart_r <= 1'b0;
      end
      else if (clkEn)
      begin
         statusWord_r <= statusWord_nxt;
         state_r <= state_nxt;
         opCount_r <= opCount_nxt;
         answer_r <= answer_nxt;
         arrayOpStart_r <= arrayOpStart_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign statusWord = statusWord_r;
   assign answer = answer_r;
   assign fourLanePins = statusWord_r[`FSP_BIT_FOUR_LANE];
   assign securityReadOnly = statusWord_r[`FSP_BIT_SEC_LOCK];
   assign arrayOpStart = arrayOpStart_r;
endmodule

/* File: tb/flash_status_protection_bench.sv */
// Self-checking bench for the flash status word block.
// Assumes the host model and the bound checker.
`timescale 1ns/100ps
module flash_status_protection_bench;
   import fsp_pkg::*;
   logic core_clk, resetn, clkEn, protectPinN, reqValid;
   logic fourLanePins, securityReadOnly, arrayOpStart;
   fsp_req_type req;
   fsp_ans_type answer;
   logic [15:0] statusWord;
   int err_total, cmp_count, cycles;
   fsp_cmd_type ops [3] = '{FSP_CMD_PROG, FSP_CMD_SERASE, FSP_CMD_BERASE};
   fsp_status_word fsp_status_word_inst (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
      .reqValid(reqValid), .req(req), .protectPinN(protectPinN), .statusWord(statusWord),
      .answer(answer), .fourLanePins(fourLanePins), .securityReadOnly(securityReadOnly),
      .arrayOpStart(arrayOpStart));
   fsp_host_model fsp_host_model_inst (.core_clk(core_clk), .reqValid(reqValid), .req(req),
      .answer(answer), .arrayOpStart(arrayOpStart));
   ////////////////////////////////////////////////////////////////////////////////////////
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask
   task cmd(input fsp_cmd_type op, input logic [19:0] addr, input logic [15:0] data);
      fsp_host_model_inst.issue(op, addr, data);
   endtask
   task waitIdle();
      for (int i = 0; i < 40 && statusWord[0] !== 1'b0; i++)
      begin
         @(posedge core_clk);
         #1;
      end
   endtask
   task status_write_cmd(input logic [15:0] data);
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      cmd(FSP_CMD_STATUS_WRITE_CMD, 20'h00000, data);
      waitIdle();
   endtask
   function automatic logic [15:0] ans();
      return {14'h0000, fsp_host_model_inst.lastAns};
   endfunction
   task conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         err_total++;
         conclude();
      end
   end
   initial
   begin
      resetn = 1'b0;
      clkEn = 1'b1;
      protectPinN = 1'b1;
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      chk("reset word", 16'h0000, statusWord);
      @(posedge core_clk) clkEn <= 1'b0;
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      chk("frozen", 16'h0000, statusWord);
      @(posedge core_clk) clkEn <= 1'b1;
      cmd(FSP_CMD_STATUS_WRITE_CMD, 20'h00000, 16'h4010);
      chk("no latch", 16'h0001, ans());
      cmd(FSP_CMD_PROG, 20'h80000, 16'h0000);
      chk("prog no latch", 16'h0001, ans());
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      chk("latch", 16'h0002, statusWord);
      cmd(FSP_CMD_WRDI, 20'h00000, 16'h0000);
      chk("latch off", 16'h0000, statusWord);
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      cmd(FSP_CMD_STATUS_WRITE_CMD, 20'h00000, 16'h5810);
      chk("write busy", 16'h0001, statusWord & 16'h0003);
      waitIdle();
      chk("word", 16'h4010, statusWord);
      $display("test status write done");
      foreach (ops[i])
      begin
         cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
         cmd(ops[i], 20'h7FFFF, 16'h0000);
         chk("inside range", 16'h0001, ans());
         cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
         cmd(ops[i], 20'h80000, 16'h0000);
         chk("outside range", 16'h0005,
            {13'h0000, fsp_host_model_inst.lastAns, fsp_host_model_inst.lastStart});
         waitIdle();
      end
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      cmd(FSP_CMD_CERASE, 20'h00000, 16'h0000);
      chk("chip erase gated", 16'h0001, ans());
      status_write_cmd(16'h401C);
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      cmd(FSP_CMD_CERASE, 20'h00000, 16'h0000);
      chk("chip erase", 16'h0002, ans());
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      chk("busy refuse", 16'h0001, ans());
      repeat (7) @(posedge core_clk);
      cmd(FSP_CMD_SUSPEND, 20'h00000, 16'h0000);
      chk("suspend", 16'h8000, statusWord & 16'h8001);
      cmd(FSP_CMD_RESUME, 20'h00000, 16'h0000);
      chk("resume", 16'h0000, statusWord & 16'h8000);
      cmd(FSP_CMD_FAST_ON, 20'h00000, 16'h0000);
      chk("fast on", 16'h2000, statusWord & 16'h2000);
      cmd(FSP_CMD_FAST_OFF, 20'h00000, 16'h0000);
      chk("fast off", 16'h0000, statusWord & 16'h2000);
      status_write_cmd(16'h4034);
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      cmd(FSP_CMD_PROG, 20'h00000, 16'h0000);
      chk("inverted none", 16'h0002, ans());
      waitIdle();
      $display("test array protection done");
      status_write_cmd(16'h0080);
      @(posedge core_clk) protectPinN <= 1'b0;
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      cmd(FSP_CMD_STATUS_WRITE_CMD, 20'h00000, 16'h0000);
      chk("pin low lock", 16'h0001, ans());
      @(posedge core_clk) protectPinN <= 1'b1;
      status_write_cmd(16'h0680);
      chk("pin high", 16'h0680, statusWord);
      chk("pins", 16'h0003, {fourLanePins, securityReadOnly});
      status_write_cmd(16'h0100);
      chk("sticky lock", 16'h0500, statusWord);
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      cmd(FSP_CMD_STATUS_WRITE_CMD, 20'h00000, 16'h0000);
      chk("power lock", 16'h0001, ans());
      @(posedge core_clk) resetn <= 1'b0;
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      chk("cycled", 16'h0000, statusWord & 16'h8180);
      status_write_cmd(16'h0180);
      cmd(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000);
      cmd(FSP_CMD_STATUS_WRITE_CMD, 20'h00000, 16'h0000);
      chk("permanent lock", 16'h0001, ans());
      $display("test lock modes done");
      conclude();
   end
endmodule

/* File: tb/fsp_host_model.sv */
// Host side model issuing decoded flash commands.
// Assumes the bench calls issue from its main process.
`timescale 1ns/100ps
module fsp_host_model
   import fsp_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Command side
   output logic reqValid,
   output fsp_pkg::fsp_req_type req,
   input fsp_pkg::fsp_ans_type answer,
   input wire logic arrayOpStart
);
   fsp_ans_type lastAns;
   logic lastStart;
   initial
   begin
      reqValid = 1'b0;
      req = '{FSP_CMD_NONE, 20'h00000, 16'h0000};
   end
   // Released address and data lines show the inverse so stale values cannot pass
   task issue(input fsp_cmd_type op, input logic [19:0] addr, input logic [15:0] data);
      @(posedge core_clk);
      reqValid <= 1'b1;
      req <= '{op, addr, data};
      @(posedge core_clk);
      reqValid <= 1'b0;
      req <= '{op, ~addr, ~data};
      #1;
      lastAns = answer;
      lastStart = arrayOpStart;
   endtask
endmodule

/* File: tb/fsp_status_word_sva.sv */
// Port checker for the flash status word block.
// Assumes the bind below reaches every top-level port.
`timescale 1ns/100ps
module fsp_status_word_sva
   import fsp_pkg::*;
(
   // Watched ports
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire logic reqValid,
   input fsp_pkg::fsp_req_type req,
   input wire logic protectPinN,
   input wire logic [15:0] statusWord,
   input fsp_pkg::fsp_ans_type answer,
   input wire logic fourLanePins,
   input wire logic securityReadOnly,
   input wire logic arrayOpStart
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   logic take;
   assign take = reqValid && clkEn;
   sequence op_start;
      arrayOpStart;
   endsequence
   sequence busy_run;
      statusWord[0] [*8];
   endsequence
   busy_hold_a: assert property (op_start |-> busy_run)
      else $error("busy dropped early");
   latch_gate_a: assert property (
      take && req.op == FSP_CMD_STATUS_WRITE_CMD && !statusWord[1] |=> answer.rejected)
      else $error("status write without latch not refused");
   pin_lock_a: assert property (
      take && req.op == FSP_CMD_STATUS_WRITE_CMD && statusWord[8:7] == 2'b01 && !protectPinN
      && !statusWord[9] |=> answer.rejected)
      else $error("status write with pin low not refused");
   hard_lock_a: assert property (
      take && req.op == FSP_CMD_STATUS_WRITE_CMD && statusWord[8] |=> answer.rejected)
      else $error("status write in lock mode not refused");
   reserved_zero_a: assert property (statusWord[12:11] == 2'b00)
      else $error("reserved bits not zero");
   sec_sticky_a: assert property (statusWord[10] |=> statusWord[10])
      else $error("security lock cleared");
   pin_mirror_a: assert property (
      fourLanePins == statusWord[9] && securityReadOnly == statusWord[10])
      else $error("pin outputs differ from status bits");
   latch_drop_a: assert property (answer.accepted |-> !statusWord[1])
      else $error("latch kept after accepted write");
   latch_set_a: assert property (
      take && req.op == FSP_CMD_WRITE_ENABLE_CMD && !statusWord[0] |=> statusWord[1])
      else $error("latch not set");
   susp_flag_a: assert property (take && req.op == FSP_CMD_SUSPEND && statusWord[0] |=> statusWord[15])
      else $error("suspend flag not set");
endmodule
bind fsp_status_word fsp_status_word_sva fsp_status_word_sva_inst (.core_clk(core_clk),
   .resetn(resetn), .clkEn(clkEn), .reqValid(reqValid), .req(req), .protectPinN(protectPinN),
   .statusWord(statusWord), .answer(answer), .fourLanePins(fourLanePins),
   .securityReadOnly(securityReadOnly), .arrayOpStart(arrayOpStart));
